// ### logic/mibc_device.sv
// per-port statistics counters behind an indirect read window
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - group and single-destination tx frames at 0x19/0x1A
// - postponed first attempt counted at 0x1B
// - all collisions at 0x1C, half duplex only
// - abandoned frames after excess collisions at 0x1D
// - one-hit 0x1E, many-hits 0x1F successful frames
// - port 4 base 0x60, port 5 base 0x80
// - word bit 31 flags counter overflow
// - bit 30 valid, bits 29..0 value from zero
// - tx drop counters at 0x100..0x104
// - rx drop counters at 0x105..0x109
// - drop counters carry no overflow or valid
// - thirty-two counters kept for every port
// - host selects statistics table with 0x1c
// - writing offset low byte starts the read
// - word shown msb first in 117..120
// - host rereads from 117 while invalid
// - per-port counter cleared when read
// - drop counters keep value after read
// - drop read uses 0x1d, bytes 119/120
module mibc_device (
  input wire logic core_clk,
  input wire logic rst_n,
  mibc_regport_if.dev rp,
  input wire logic cnt_inc_valid,
  input wire logic [2:0] cnt_inc_port,
  input wire logic [4:0] cnt_inc_idx,
  input wire logic [4:0] tx_group_frame_count_evt,
  input wire logic [4:0] tx_single_dest_frame_count_evt,
  input wire logic [4:0] tx_postponed_count_evt,
  input wire logic [4:0] tx_all_collisions_count_evt,
  input wire logic [4:0] tx_abandoned_count_evt,
  input wire logic [4:0] tx_one_hit_count_evt,
  input wire logic [4:0] tx_many_hits_count_evt,
  input wire logic [4:0] port_half_duplex,
  input wire logic [4:0] tx_drop_evt,
  input wire logic [4:0] rx_drop_evt,
  output logic read_pending
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // counter store
  logic [mibc_pkg::CNT_W-1:0] cnt_mem [0:mibc_pkg::PORT_CNT-1];
  logic ovf_mem [0:mibc_pkg::PORT_CNT-1];
  logic [mibc_pkg::DROP_W-1:0] drop_mem [0:mibc_pkg::NUM_DROP-1];
  logic [mibc_pkg::PORT_CNT-1:0] inc_vec;
  logic [mibc_pkg::NUM_DROP-1:0] drop_inc;
  logic [7:0] sel_reg;
  logic [7:0] trig_reg;
  logic pend_reg;
  logic [31:0] word_reg;
  logic [7:0] rdata_reg;
  logic rd_done_reg;

  // ----------------------------------------------------------------
  // increment decode
  // ----------------------------------------------------------------
  // ports are contiguous blocks of 32, so the linear index is the offset
  genvar gp;
  genvar gi;
  generate
    for (gp = 0; gp < mibc_pkg::NUM_PORTS; gp++) begin : g_port
      for (gi = 0; gi < mibc_pkg::PORT_STRIDE; gi++) begin : g_idx
        wire gen_hit;
        wire tx_hit;
        assign gen_hit = cnt_inc_valid && (cnt_inc_port == 3'(gp))
                         && (cnt_inc_idx == 5'(gi));
        assign tx_hit =
          ((5'(gi) == mibc_pkg::OFF_TX_GROUP) && tx_group_frame_count_evt[gp]) ||
          ((5'(gi) == mibc_pkg::OFF_TX_SINGLE) && tx_single_dest_frame_count_evt[gp]) ||
          ((5'(gi) == mibc_pkg::OFF_TX_POSTPONED) && tx_postponed_count_evt[gp]) ||
          ((5'(gi) == mibc_pkg::OFF_TX_ALL_COLL) && tx_all_collisions_count_evt[gp]
            && port_half_duplex[gp]) ||
          ((5'(gi) == mibc_pkg::OFF_TX_ABANDONED) && tx_abandoned_count_evt[gp]) ||
          ((5'(gi) == mibc_pkg::OFF_TX_ONE_HIT) && tx_one_hit_count_evt[gp]) ||
          ((5'(gi) == mibc_pkg::OFF_TX_MANY_HITS) && tx_many_hits_count_evt[gp]);
        assign inc_vec[gp * mibc_pkg::PORT_STRIDE + gi] = gen_hit || tx_hit;
      end
    end
  endgenerate

  assign drop_inc = {rx_drop_evt, tx_drop_evt};

  // ----------------------------------------------------------------
  // indirect address decode
  // ----------------------------------------------------------------
  wire [9:0] cnt_addr;
  wire tbl_sel;
  wire is_port;
  wire is_drop;
  wire [9:0] drop_off;
  wire [3:0] drop_idx;
  wire [7:0] port_idx;
  wire trig_wr;
  wire sel_wr;
  wire latch;
  wire [31:0] snap;
  // select bits as address bits 9:8
  assign cnt_addr = {sel_reg[1:0], trig_reg};
  assign tbl_sel = (sel_reg[7:mibc_pkg::SEL_TABLE_LSB]
                    == mibc_pkg::SEL_MIB[7:mibc_pkg::SEL_TABLE_LSB]);
  assign is_port = tbl_sel && (cnt_addr < mibc_pkg::PORT_END);
  assign is_drop = tbl_sel && (cnt_addr >= mibc_pkg::DROP_TX_BASE)
                   && (cnt_addr <= mibc_pkg::DROP_END);
  assign drop_off = cnt_addr - mibc_pkg::DROP_TX_BASE;
  assign drop_idx = drop_off[3:0];
  assign port_idx = cnt_addr[7:0];
  assign sel_wr = rp.reg_wr && (rp.reg_addr == mibc_pkg::REG_SEL);
  assign trig_wr = rp.reg_wr && (rp.reg_addr == mibc_pkg::REG_TRIG);
  assign latch = pend_reg;
  // word layout; drop words have no flags
  assign snap = is_port ? {ovf_mem[port_idx], 1'b1, cnt_mem[port_idx]}
              : is_drop ? {16'h0000, drop_mem[drop_idx]}
              : 32'h00000000;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // clearing on read and counting in the same cycle keeps the new event
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < mibc_pkg::PORT_CNT; i++) begin
      if (!rst_n) begin
        cnt_mem[i] <= '0;
        ovf_mem[i] <= 1'b0;
      end else if (latch && is_port && (port_idx == 8'(i))) begin
        cnt_mem[i] <= CNT_W_ONE(inc_vec[i]);
        ovf_mem[i] <= 1'b0;
      end else if (inc_vec[i]) begin
        cnt_mem[i] <= cnt_mem[i] + 30'h00000001;
        if (&cnt_mem[i]) begin
          ovf_mem[i] <= 1'b1;
        end
      end
    end
  end

  function automatic logic [mibc_pkg::CNT_W-1:0] CNT_W_ONE(input logic b);
    CNT_W_ONE = {29'h00000000, b};
  endfunction : CNT_W_ONE

  // drop counters never cleared by access
  always_ff @(posedge core_clk) begin
    for (int j = 0; j < mibc_pkg::NUM_DROP; j++) begin
      if (!rst_n) begin
        drop_mem[j] <= '0;
      end else if (drop_inc[j]) begin
        drop_mem[j] <= drop_mem[j] + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // window registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_reg <= 8'h00;
      trig_reg <= 8'h00;
      pend_reg <= 1'b0;
      word_reg <= 32'h00000000;
    end else begin
      if (sel_wr) begin
        sel_reg <= rp.reg_wdata;
      end
      if (trig_wr) begin
        trig_reg <= rp.reg_wdata;
        pend_reg <= 1'b1;
        word_reg <= 32'h00000000;
      end else if (latch) begin
        pend_reg <= 1'b0;
        word_reg <= snap;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // one cycle answer; the data window reads zero until the capture lands
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (rp.reg_addr)
      mibc_pkg::REG_SEL: rd_mux = sel_reg;
      mibc_pkg::REG_TRIG: rd_mux = trig_reg;
      mibc_pkg::REG_DATA0: rd_mux = word_reg[31:24];
      mibc_pkg::REG_DATA1: rd_mux = word_reg[23:16];
      mibc_pkg::REG_DATA2: rd_mux = word_reg[15:8];
      mibc_pkg::REG_DATA3: rd_mux = word_reg[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rd_done_reg <= 1'b0;
    end else begin
      rd_done_reg <= rp.reg_rd;
      if (rp.reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign rp.reg_rdata = rdata_reg;
  assign rp.reg_rd_done = rd_done_reg;
  assign read_pending = pend_reg;
endmodule : mibc_device
`default_nettype wire

// ### logic/mibc_host.sv
// host controller: apb command registers driving the indirect counter read
`timescale 1ns/1ps
`default_nettype none
module mibc_host (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  mibc_regport_if.host rp
);
  typedef enum logic [2:0] {H_IDLE, H_SEL, H_TRIG, H_READ, H_WAIT} mibc_hstate_type;

  mibc_hstate_type state_reg;
  logic [9:0] off_reg;
  logic [1:0] idx_reg;
  logic [31:0] result_reg;
  logic done_reg;
  logic [31:0] prdata_reg;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire [11:0] loc;
  wire setup;
  wire access;
  wire hit_cmd;
  wire hit_stat;
  wire hit_res;
  wire mapped;
  wire start;
  wire busy;
  wire is_drop;
  wire invalid_first;
  assign loc = paddr[11:0];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_cmd = (loc == mibc_pkg::APB_CMD) && (paddr[31:12] == 20'h00000);
  assign hit_stat = (loc == mibc_pkg::APB_STATUS) && (paddr[31:12] == 20'h00000);
  assign hit_res = (loc == mibc_pkg::APB_RESULT) && (paddr[31:12] == 20'h00000);
  assign mapped = hit_cmd || hit_stat || hit_res;
  assign busy = (state_reg != H_IDLE);
  // a command while busy is dropped; software polls busy first
  assign start = access && pwrite && hit_cmd && !busy;
  assign is_drop = (off_reg >= mibc_pkg::DROP_TX_BASE);
  assign invalid_first = !is_drop && (idx_reg == 2'h0)
                         && !rp.reg_rdata[mibc_pkg::VALID_BIT_IN_BYTE];
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_reg <= hit_cmd ? {22'h000000, off_reg}
                  : hit_stat ? {30'h00000000, done_reg, busy}
                  : hit_res ? result_reg : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // register port sequence
  // ----------------------------------------------------------------
  // select code carries address bits 9:8
  assign rp.reg_wdata = (state_reg == H_SEL)
                        ? {mibc_pkg::SEL_MIB[7:mibc_pkg::SEL_TABLE_LSB], off_reg[9:8]}
                        : off_reg[7:0];
  assign rp.reg_wr = (state_reg == H_SEL) || (state_reg == H_TRIG);
  assign rp.reg_rd = (state_reg == H_READ);
  assign rp.reg_addr = (state_reg == H_SEL) ? mibc_pkg::REG_SEL
                     : (state_reg == H_TRIG) ? mibc_pkg::REG_TRIG
                     : (mibc_pkg::REG_DATA0 + {6'h00, idx_reg});

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= H_IDLE;
      off_reg <= 10'h000;
      idx_reg <= 2'h0;
      result_reg <= 32'h00000000;
      done_reg <= 1'b0;
    end else begin
      case (state_reg)
        H_IDLE: begin
          if (start) begin
            off_reg <= pwdata[9:0];
            done_reg <= 1'b0;
            state_reg <= H_SEL;
          end
        end
        H_SEL: begin
          state_reg <= H_TRIG;
        end
        H_TRIG: begin
          idx_reg <= is_drop ? mibc_pkg::DROP_FIRST_BYTE : 2'h0;
          result_reg <= 32'h00000000;
          state_reg <= H_READ;
        end
        H_READ: begin
          state_reg <= H_WAIT;
        end
        H_WAIT: begin
          if (rp.reg_rd_done) begin
            result_reg[8 * (3 - idx_reg) +: 8] <= rp.reg_rdata;
            if (invalid_first) begin
              state_reg <= H_READ;
            end else if (idx_reg == mibc_pkg::LAST_BYTE) begin
              done_reg <= 1'b1;
              state_reg <= H_IDLE;
            end else begin
              idx_reg <= idx_reg + 2'h1;
              state_reg <= H_READ;
            end
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule : mibc_host
`default_nettype wire

// ### pkg/mibc_pkg.sv
// shared constants for the statistics counter window and its host controller
package mibc_pkg;
  // ----------------------------------------------------------------
  // indirect access registers of the device port
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SEL = 8'h6E;
  localparam logic [7:0] REG_TRIG = 8'h6F;
  localparam logic [7:0] REG_DATA0 = 8'h75;
  localparam logic [7:0] REG_DATA1 = 8'h76;
  localparam logic [7:0] REG_DATA2 = 8'h77;
  localparam logic [7:0] REG_DATA3 = 8'h78;
  localparam logic [1:0] DROP_FIRST_BYTE = 2'h2;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  // ----------------------------------------------------------------
  // table select codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_MIB = 8'h1C;
  localparam logic [7:0] SEL_DROP = 8'h1D;
  localparam int SEL_TABLE_LSB = 2;
  // ----------------------------------------------------------------
  // counter space
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 5;
  localparam int PORT_STRIDE = 32;
  localparam int PORT_CNT = NUM_PORTS * PORT_STRIDE;
  localparam int NUM_DROP = 10;
  localparam int CNT_W = 30;
  localparam int DROP_W = 16;
  localparam int OVF_BIT = 31;
  localparam int VALID_BIT = 30;
  localparam int VALID_BIT_IN_BYTE = VALID_BIT - 24;
  localparam logic [9:0] PORT_END = 10'h0A0;
  localparam logic [9:0] DROP_TX_BASE = 10'h100;
  localparam logic [9:0] DROP_RX_BASE = 10'h105;
  localparam logic [9:0] DROP_END = 10'h109;
  localparam logic [4:0] OFF_TX_GROUP = 5'h19;
  localparam logic [4:0] OFF_TX_SINGLE = 5'h1A;
  localparam logic [4:0] OFF_TX_POSTPONED = 5'h1B;
  localparam logic [4:0] OFF_TX_ALL_COLL = 5'h1C;
  localparam logic [4:0] OFF_TX_ABANDONED = 5'h1D;
  localparam logic [4:0] OFF_TX_ONE_HIT = 5'h1E;
  localparam logic [4:0] OFF_TX_MANY_HITS = 5'h1F;
  // ----------------------------------------------------------------
  // host controller apb map
  // ----------------------------------------------------------------
  localparam logic [11:0] APB_CMD = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_RESULT = 12'h008;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
endpackage : mibc_pkg

// ### pkg/mibc_regport_if.sv
// byte-wide register port between host controller and counter window
`timescale 1ns/1ps
`default_nettype none
interface mibc_regport_if;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rd_done;
  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rd_done
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_rd_done
  );
endinterface : mibc_regport_if
`default_nettype wire

// ### verif/mibc_assertions.sv
// concurrent checks on the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module mibc_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_done
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [7:0] last_rd_reg;
  logic drop_sel_reg;
  // drop table is remembered from the select byte, not from the trigger
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_rd_reg <= 8'h00;
      drop_sel_reg <= 1'b0;
    end else begin
      if (reg_rd)
        last_rd_reg <= reg_addr;
      if (reg_wr && reg_addr == mibc_pkg::REG_SEL)
        drop_sel_reg <= (reg_wdata[1:0] != 2'h0);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_done_after_read: assert property (reg_rd |=> reg_rd_done)
    else $error("read answer missing");
  a_done_needs_read: assert property (reg_rd_done |-> $past(reg_rd))
    else $error("read answer without request");
  a_one_request: assert property (!(reg_wr && reg_rd))
    else $error("write and read together");
  a_sel_code: assert property (reg_wr && reg_addr == mibc_pkg::REG_SEL
    |-> reg_wdata[7:2] == mibc_pkg::SEL_MIB[7:2])
    else $error("bad table select code");
  a_trig_after_sel: assert property (reg_wr && reg_addr == mibc_pkg::REG_SEL
    |=> reg_wr && reg_addr == mibc_pkg::REG_TRIG)
    else $error("trigger does not follow select");
  a_first_byte: assert property (reg_wr && reg_addr == mibc_pkg::REG_TRIG
    |=> reg_rd && reg_addr == (drop_sel_reg ? mibc_pkg::REG_DATA2 : mibc_pkg::REG_DATA0))
    else $error("wrong first data byte");
  a_msb_order: assert property (reg_rd && !drop_sel_reg && reg_addr > mibc_pkg::REG_DATA0
    |-> last_rd_reg == reg_addr - 8'h01)
    else $error("data bytes out of order");
  a_drop_window: assert property (reg_rd && drop_sel_reg
    |-> reg_addr == mibc_pkg::REG_DATA2 || reg_addr == mibc_pkg::REG_DATA3)
    else $error("drop read outside its bytes");
  a_reread_invalid: assert property (reg_rd_done && last_rd_reg == mibc_pkg::REG_DATA0
    && !reg_rdata[mibc_pkg::VALID_BIT_IN_BYTE]
    |-> ##[1:2] reg_rd && reg_addr == mibc_pkg::REG_DATA0)
    else $error("invalid word not reread");
  a_rdata_holds: assert property (!reg_rd_done |-> $stable(reg_rdata))
    else $error("read byte moved without a read");
  c_reread: cover property (reg_rd_done && last_rd_reg == mibc_pkg::REG_DATA0
    && !reg_rdata[mibc_pkg::VALID_BIT_IN_BYTE]);
  c_drop_read: cover property (reg_rd && drop_sel_reg);
  c_full_word: cover property (reg_rd && !drop_sel_reg && reg_addr == mibc_pkg::REG_DATA3);
endmodule : mibc_checker
`default_nettype wire

// ### verif/mibc_counter_indirect_read_tb_top.sv
// self-checking bench for the counter window and its host controller
`timescale 1ns/1ps
`default_nettype none
module mib_counter_indirect_read_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cnt_inc_valid = 1'b0;
  logic [2:0] cnt_inc_port = 3'h0;
  logic [4:0] cnt_inc_idx = 5'h0;
  logic [4:0] ev [0:8] = '{default: 5'h0};
  logic [4:0] half_dup = 5'h1F;
  logic read_pending;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int compares = 0;
  int n;
  mibc_regport_if rp_if ();
  mibc_device mibc_device_inst (.core_clk(core_clk), .rst_n(rst_n), .rp(rp_if),
    .cnt_inc_valid(cnt_inc_valid), .cnt_inc_port(cnt_inc_port), .cnt_inc_idx(cnt_inc_idx),
    .tx_group_frame_count_evt(ev[0]), .tx_single_dest_frame_count_evt(ev[1]),
    .tx_postponed_count_evt(ev[2]), .tx_all_collisions_count_evt(ev[3]),
    .tx_abandoned_count_evt(ev[4]), .tx_one_hit_count_evt(ev[5]),
    .tx_many_hits_count_evt(ev[6]), .port_half_duplex(half_dup),
    .tx_drop_evt(ev[7]), .rx_drop_evt(ev[8]), .read_pending(read_pending));
  mibc_host mibc_host_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rp(rp_if));
  mibc_checker mibc_checker_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(rp_if.reg_wr),
    .reg_rd(rp_if.reg_rd), .reg_addr(rp_if.reg_addr), .reg_wdata(rp_if.reg_wdata),
    .reg_rdata(rp_if.reg_rdata), .reg_rd_done(rp_if.reg_rd_done));
  always #5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // expectations and compares
  // ----------------------------------------------------------------
  function logic [31:0] exp_port(input int cnt);
    return {1'b0, 1'b1, 30'(cnt)};
  endfunction : exp_port
  // drop words carry no flags, so the upper half stays zero
  function logic [31:0] exp_drop(input int cnt);
    return {16'h0, 16'(cnt)};
  endfunction : exp_drop
  task chk32(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk32
  task chk1(input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk1
  task tally_and_finish;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // the poll count is bounded so a stuck controller cannot hang the run
  task read_cnt(input logic [9:0] a);
    int i;
    apb(1'b1, mibc_pkg::APB_CMD, {22'h0, a});
    i = 0;
    do begin
      apb(1'b0, mibc_pkg::APB_STATUS, 32'h0);
      i++;
    end while (rd[mibc_pkg::STAT_DONE_BIT] !== 1'b1 && i < 100);
    chk1(1'b1, rd[mibc_pkg::STAT_DONE_BIT]);
    chk1(1'b0, read_pending);
    apb(1'b0, mibc_pkg::APB_RESULT, 32'h0);
  endtask : read_cnt
  task pulse(input int k, input int p, input int cnt);
    repeat (cnt) begin
      @(posedge core_clk);
      ev[k][p] <= 1'b1;
      @(posedge core_clk);
      ev[k] <= 5'h0;
    end
  endtask : pulse
  task inc(input int p, input logic [4:0] idx, input int cnt);
    repeat (cnt) begin
      @(posedge core_clk);
      cnt_inc_valid <= 1'b1;
      cnt_inc_port <= 3'(p);
      cnt_inc_idx <= idx;
      @(posedge core_clk);
      cnt_inc_valid <= 1'b0;
    end
  endtask : inc
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #500000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(96974));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, mibc_pkg::APB_STATUS, 32'h0);
    chk32(32'h0, rd);
    apb(1'b0, mibc_pkg::APB_RESULT, 32'h0);
    chk32(32'h0, rd);
    for (int p = 0; p < 5; p++) begin
      for (int k = 0; k < 7; k++) begin
        n = $urandom_range(1, 6);
        pulse(k, p, n);
        read_cnt(10'(p * mibc_pkg::PORT_STRIDE + k) + {5'h0, mibc_pkg::OFF_TX_GROUP});
        chk32(exp_port(n), rd);
        read_cnt(10'(p * mibc_pkg::PORT_STRIDE + k) + {5'h0, mibc_pkg::OFF_TX_GROUP});
        chk32(exp_port(0), rd);
      end
    end
    half_dup <= 5'h00;
    pulse(3, 2, 3);
    read_cnt(10'h040 + {5'h0, mibc_pkg::OFF_TX_ALL_COLL});
    chk32(exp_port(0), rd);
    half_dup <= 5'h1F;
    for (int p = 0; p < 2; p++) begin
      n = $urandom_range(1, 6);
      inc(p, 5'h0E, n);
      read_cnt(10'(p * mibc_pkg::PORT_STRIDE + 14));
      chk32(exp_port(n), rd);
    end
    for (int d = 0; d < 10; d++) begin
      n = $urandom_range(1, 6);
      pulse(7 + d / 5, d % 5, n);
      read_cnt(mibc_pkg::DROP_TX_BASE + 10'(d));
      chk32(exp_drop(n), rd);
      read_cnt(mibc_pkg::DROP_TX_BASE + 10'(d));
      chk32(exp_drop(n), rd);
    end
    apb(1'b0, mibc_pkg::APB_CMD, 32'h0);
    chk32({22'h0, mibc_pkg::DROP_END}, rd);
    chk1(1'b0, er);
    apb(1'b0, 12'h00C, 32'h0);
    chk1(1'b1, er);
    chk32(32'h0, rd);
    tally_and_finish;
  end
endmodule : mib_counter_indirect_read_tb_top
`default_nettype wire
